// File: rtl/bcs_stat_bank.v
/*
 * Broadcast frame, broadcast octet and carrier-loss statistics counters.
 * Assumes MAC event inputs are synchronous one-cycle pulses or levels on
 * CLK_SYS, and the host access port is a simple synchronous strobe port.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bcs_stat_defs.vh"

module bcs_stat_bank (
   input wire CLK_SYS,                   // 200 MHz system clock
   input wire RESET,                     // Synchronous reset, high
   input wire GLOBAL_COUNT_ENABLE,       // Statistics enable from control reg
   input wire [4:0] PER_COUNTER_MASK,    // One mask bit per counter, 1 stops
   input wire RX_FRAME_DONE,             // Pulse at end of a received frame
   input wire RX_BROADCAST,              // Destination is all ones
   input wire RX_TOO_LONG,               // Frame too long
   input wire RX_FCS_ERR,                // FCS error
   input wire RX_LEN_ERR,                // Length error
   input wire RX_ALIGN_ERR,              // Alignment error
   input wire RX_OVERRUN,                // Lost to internal overrun
   input wire [15:0] RX_OCTETS,          // Data and pad octets
   input wire RX_VLAN_STRIPPED,          // Tag removed, not in RX_OCTETS
   input wire TX_FRAME_DONE,             // Pulse at end of a sent frame
   input wire TX_OK,                     // Frame sent successfully
   input wire TX_BROADCAST,              // Destination is all ones
   input wire [15:0] TX_OCTETS,          // Data and pad octets
   input wire TX_VLAN_INSERTED,          // Tag added, not in TX_OCTETS
   input wire TX_ACTIVE,                 // Frame on the wire
   input wire TX_SFD_SENT,               // Preamble and delimiter gone out
   input wire TX_COLLISION,              // Collision seen
   input wire CRS,                       // Carrier sense
   input wire [8:0] HOST_ADDR,           // Byte offset in the window
   input wire HOST_WR,                   // Write strobe
   input wire [31:0] HOST_WDATA,         // Write data
   input wire HOST_RD,                   // Read strobe
   output reg [31:0] HOST_RDATA,         // Read data, one cycle after HOST_RD
   output reg HOST_RVALID,               // Read data valid pulse
   output reg COUNTER_THRESHOLD_EVENT    // Pulse to set statistics-update flag
);

   // ********************************************
   // Event qualification
   // ********************************************
   wire rx_bad;
   wire rx_good_bcast;
   wire tx_good_bcast;
   wire [15:0] rx_amount;
   wire [15:0] tx_amount;
   wire [4:0] allow;
   wire carrier_drop;
   reg crs_prev;
   reg frame_collided;

   // Any error disqualifies the frame from every receive statistic
   assign rx_bad = RX_TOO_LONG | RX_FCS_ERR | RX_LEN_ERR | RX_ALIGN_ERR | RX_OVERRUN;
   assign rx_good_bcast = RX_FRAME_DONE & RX_BROADCAST & ~rx_bad;
   // Other multicast frames never carry the broadcast flag
   assign tx_good_bcast = TX_FRAME_DONE & TX_OK & TX_BROADCAST;

   // Restore the tag octets the MAC added or removed behind our back
   assign rx_amount = RX_OCTETS + (RX_VLAN_STRIPPED ? `BCS_VLAN_OCTETS : 16'h0000);
   assign tx_amount = TX_OCTETS + (TX_VLAN_INSERTED ? `BCS_VLAN_OCTETS : 16'h0000);

   // Enable per counter: global on, own mask bit clear
   assign allow = {`BCS_MASK_W{GLOBAL_COUNT_ENABLE}} & ~PER_COUNTER_MASK;

   // Carrier tracking: only watched after the delimiter, and a frame that
   // has collided stops counting for the rest of that frame
   always @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         crs_prev <= 1'b0;
         frame_collided <= 1'b0;
      end
      else
      begin
         crs_prev <= CRS;
         if (!TX_ACTIVE)
            frame_collided <= 1'b0;
         else if (TX_COLLISION)
            frame_collided <= 1'b1;
      end
   end

   assign carrier_drop = TX_ACTIVE & TX_SFD_SENT & crs_prev & ~CRS
                         & ~TX_COLLISION & ~frame_collided;

   // ********************************************
   // Host write decode
   // ********************************************
   wire ld_rx_frame;
   wire ld_tx_frame;
   wire ld_rx_octet;
   wire ld_tx_octet;
   wire ld_carrier;

   // Software keeps its access no wider than the register, so 16-bit
   // registers take only the low half of the write data
   assign ld_rx_frame = HOST_WR & (HOST_ADDR == `BCS_OFF_RX_FRAME);
   assign ld_tx_frame = HOST_WR & (HOST_ADDR == `BCS_OFF_TX_FRAME);
   assign ld_rx_octet = HOST_WR & (HOST_ADDR == `BCS_OFF_RX_OCTET);
   assign ld_tx_octet = HOST_WR & (HOST_ADDR == `BCS_OFF_TX_OCTET);
   assign ld_carrier = HOST_WR & (HOST_ADDR == `BCS_OFF_CARRIER);

   // ********************************************
   // Counters
   // ********************************************
   wire [15:0] rx_frame_count;
   wire [15:0] tx_frame_count;
   wire [31:0] rx_octet_count;
   wire [31:0] tx_octet_count;
   wire [15:0] carrier_count;
   wire [4:0] hit;

   bcs_stat_counter #(.WIDTH(`BCS_W16), .THRESH(`BCS_TH16)) u_rx_frame (
      .clk(CLK_SYS),
      .reset(RESET),
      .step(rx_good_bcast & allow[`BCS_MB_RX_FRAME]),
      .amount(16'h0001),
      .load(ld_rx_frame),
      .load_val(HOST_WDATA[15:0]),
      .value(rx_frame_count),
      .hit(hit[`BCS_MB_RX_FRAME])
   );

   bcs_stat_counter #(.WIDTH(`BCS_W16), .THRESH(`BCS_TH16)) u_tx_frame (
      .clk(CLK_SYS),
      .reset(RESET),
      .step(tx_good_bcast & allow[`BCS_MB_TX_FRAME]),
      .amount(16'h0001),
      .load(ld_tx_frame),
      .load_val(HOST_WDATA[15:0]),
      .value(tx_frame_count),
      .hit(hit[`BCS_MB_TX_FRAME])
   );

   bcs_stat_counter #(.WIDTH(`BCS_W32), .THRESH(`BCS_TH32)) u_rx_octet (
      .clk(CLK_SYS),
      .reset(RESET),
      .step(rx_good_bcast & allow[`BCS_MB_RX_OCTET]),
      .amount(rx_amount),
      .load(ld_rx_octet),
      .load_val(HOST_WDATA),
      .value(rx_octet_count),
      .hit(hit[`BCS_MB_RX_OCTET])
   );

   // Wraps at the full 32-bit range; a 24-bit wrap would never reach
   // the threshold at 0xc0000000
   bcs_stat_counter #(.WIDTH(`BCS_W32), .THRESH(`BCS_TH32)) u_tx_octet (
      .clk(CLK_SYS),
      .reset(RESET),
      .step(tx_good_bcast & allow[`BCS_MB_TX_OCTET]),
      .amount(tx_amount),
      .load(ld_tx_octet),
      .load_val(HOST_WDATA),
      .value(tx_octet_count),
      .hit(hit[`BCS_MB_TX_OCTET])
   );

   bcs_stat_counter #(.WIDTH(`BCS_W16), .THRESH(`BCS_TH16)) u_carrier (
      .clk(CLK_SYS),
      .reset(RESET),
      .step(carrier_drop & allow[`BCS_MB_CARRIER]),
      .amount(16'h0001),
      .load(ld_carrier),
      .load_val(HOST_WDATA[15:0]),
      .value(carrier_count),
      .hit(hit[`BCS_MB_CARRIER])
   );

   // ********************************************
   // Threshold event and read port
   // ********************************************
   reg [31:0] next_rdata;

   // Read mux; unmapped offsets read as zero
   always @*
   begin
      case (HOST_ADDR)
         `BCS_OFF_RX_FRAME: next_rdata = {16'h0000, rx_frame_count};
         `BCS_OFF_TX_FRAME: next_rdata = {16'h0000, tx_frame_count};
         `BCS_OFF_RX_OCTET: next_rdata = rx_octet_count;
         `BCS_OFF_TX_OCTET: next_rdata = tx_octet_count;
         `BCS_OFF_CARRIER: next_rdata = {16'h0000, carrier_count};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Outputs registered; event is one pulse per cycle in which any counter crosses
   always @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         HOST_RDATA <= 32'h00000000;
         HOST_RVALID <= 1'b0;
         COUNTER_THRESHOLD_EVENT <= 1'b0;
      end
      else
      begin
         HOST_RVALID <= HOST_RD;
         if (HOST_RD)
            HOST_RDATA <= next_rdata;
         COUNTER_THRESHOLD_EVENT <= |hit;
      end
   end

endmodule

`default_nettype wire

// File: rtl/bcs_stat_defs.vh
/*
 * Constants for the broadcast and carrier-loss statistics counters:
 * register offsets, counter widths, wrap and threshold values, mask bits.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef BCS_STAT_DEFS_VH
`define BCS_STAT_DEFS_VH

// ********************************************
// Register offsets (byte offsets in the window)
// ********************************************
`define BCS_OFF_RX_OCTET 9'h0b0
`define BCS_OFF_RX_FRAME 9'h0bc
`define BCS_OFF_TX_OCTET 9'h0d8
`define BCS_OFF_TX_FRAME 9'h0f4
`define BCS_OFF_CARRIER 9'h0f8

// ********************************************
// Counter shapes
// ********************************************
`define BCS_W16 16
`define BCS_W32 32
`define BCS_TH16 32'h0000c000
`define BCS_TH32 32'hc0000000
`define BCS_VLAN_OCTETS 16'h0004

// ********************************************
// Bit positions in the per-counter mask input
// ********************************************
`define BCS_MB_RX_FRAME 0
`define BCS_MB_TX_FRAME 1
`define BCS_MB_RX_OCTET 2
`define BCS_MB_TX_OCTET 3
`define BCS_MB_CARRIER 4
`define BCS_MASK_W 5

`endif

// File: rtl/bcs_stat_counter.v
/*
 * One wrapping statistics counter with host load and a threshold event.
 * Assumes the caller gates the step with the enable terms and that the
 * step size never exceeds the counter width.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bcs_stat_defs.vh"

module bcs_stat_counter #(
   parameter WIDTH = 16,
   parameter [31:0] THRESH = 32'h0000c000
) (
   input wire clk,                  // System clock
   input wire reset,                // Synchronous reset, high
   input wire step,                 // Add amount this cycle
   input wire [15:0] amount,        // Octets or one
   input wire load,                 // Host write
   input wire [WIDTH-1:0] load_val, // Host data
   output reg [WIDTH-1:0] value,    // Current count
   output reg hit                   // Pulse when count crosses threshold
);

   localparam [WIDTH-1:0] th = THRESH[WIDTH-1:0];

   wire [31:0] amount_ext;
   wire [WIDTH-1:0] next_value;

   // ********************************************
   // Count, wrap, load
   // ********************************************
   // Step widened to a full word, then cut to the counter width, so the
   // 16-bit case needs no empty zero fill
   assign amount_ext = {16'h0000, amount};
   // Natural binary wrap past all ones back through zero
   assign next_value = value + amount_ext[WIDTH-1:0];

   // Host load wins over a count in the same cycle; that one event is lost
   always @(posedge clk)
   begin
      if (reset)
      begin
         value <= {WIDTH{1'b0}};
         hit <= 1'b0;
      end
      else if (load)
      begin
         value <= load_val;
         hit <= 1'b0;
      end
      else if (step)
      begin
         value <= next_value;
         // Crossing test, since octet steps may jump over the exact value
         hit <= (value < th) && (next_value >= th);
      end
      else
      begin
         hit <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// File: testbench/bcs_stat_chk.sv
/* Assertions on the statistics bank host port and update pulse.
   Sees only bcs_stat_bank ports; bound at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module bcs_stat_chk (
   input wire CLK_SYS, // Clock
   input wire RESET, // Reset
   input wire GLOBAL_COUNT_ENABLE, // Enable
   input wire [4:0] PER_COUNTER_MASK, // Masks
   input wire RX_FRAME_DONE, // Rx end
   input wire TX_FRAME_DONE, // Tx end
   input wire TX_OK, // Tx good
   input wire TX_BROADCAST, // Tx bcast
   input wire TX_ACTIVE, // Tx busy
   input wire [8:0] HOST_ADDR, // Offset
   input wire HOST_WR, // Write
   input wire [31:0] HOST_WDATA, // Wdata
   input wire HOST_RD, // Read
   input wire [31:0] HOST_RDATA, // Rdata
   input wire HOST_RVALID, // Rvalid
   input wire COUNTER_THRESHOLD_EVENT // Event
);
   // ******************
   // Port relations
   // ******************
   // One domain, so clock and reset are given once
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);
   sequence wr_s(a);
      HOST_WR && HOST_ADDR == a;
   endsequence
   sequence rd_s(a);
      HOST_RD && HOST_ADDR == a;
   endsequence
   // A counted frame with no host write racing it
   sequence txok_s;
      TX_FRAME_DONE && TX_OK && TX_BROADCAST && GLOBAL_COUNT_ENABLE
         && !PER_COUNTER_MASK[1] && !HOST_WR;
   endsequence
   rd_answer_a: assert property (HOST_RD |=> HOST_RVALID)
      else $error("read gave no valid");
   valid_cause_a: assert property (HOST_RVALID |-> $past(HOST_RD))
      else $error("valid without read");
   rdata_hold_a: assert property (!HOST_RD |=> $stable(HOST_RDATA))
      else $error("read data moved");
   upper_zero_a: assert property (rd_s(9'h0bc) or rd_s(9'h0f4) or rd_s(9'h0f8)
      |=> HOST_RDATA[31:16] == 16'h0000) else $error("upper half set");
   load_half_a: assert property (wr_s(9'h0f4) ##1 rd_s(9'h0f4)
      |=> HOST_RDATA == ($past(HOST_WDATA, 2) & 32'h0000ffff)) else $error("load lost");
   load_word_a: assert property (wr_s(9'h0d8) ##1 rd_s(9'h0d8)
      |=> HOST_RDATA == $past(HOST_WDATA, 2)) else $error("word load lost");
   count_one_a: assert property (wr_s(9'h0f4) ##1 txok_s ##1 rd_s(9'h0f4)
      |=> HOST_RDATA == (($past(HOST_WDATA, 3) + 1) & 32'h0000ffff)) else $error("bad step");
   event_cause_a: assert property (COUNTER_THRESHOLD_EVENT |-> $past(RX_FRAME_DONE, 2)
      || $past(TX_FRAME_DONE, 2) || $past(TX_ACTIVE, 2)) else $error("event from nothing");
   event_enable_a: assert property (COUNTER_THRESHOLD_EVENT
      |-> $past(GLOBAL_COUNT_ENABLE, 2)) else $error("event while disabled");
endmodule
bind bcs_stat_bank bcs_stat_chk u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
   .GLOBAL_COUNT_ENABLE(GLOBAL_COUNT_ENABLE), .PER_COUNTER_MASK(PER_COUNTER_MASK),
   .RX_FRAME_DONE(RX_FRAME_DONE), .TX_FRAME_DONE(TX_FRAME_DONE), .TX_OK(TX_OK),
   .TX_BROADCAST(TX_BROADCAST), .TX_ACTIVE(TX_ACTIVE), .HOST_ADDR(HOST_ADDR),
   .HOST_WR(HOST_WR), .HOST_WDATA(HOST_WDATA), .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA),
   .HOST_RVALID(HOST_RVALID), .COUNTER_THRESHOLD_EVENT(COUNTER_THRESHOLD_EVENT));
`default_nettype wire

// File: testbench/tb.sv
/* Self-checking bench for bcs_stat_bank: random frames and carrier drops
   against a counter model, with threshold and wrap corners. Assumes the
   checker file is compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ******************
   // Stimulus and model
   // ******************
   logic clk = 0, rst = 1, ge = 0, rxd = 0, rxb = 0, rxv = 0, txd = 0, txok = 0;
   logic txb = 0, txv = 0, txa = 0, sfd = 0, col = 0, crs = 0, wr = 0, rd = 0, rv, ev;
   logic [4:0] msk = 0, rxe = 0;
   logic [15:0] rxo = 0, txo = 0;
   logic [8:0] addr = 0;
   logic [31:0] wd = 0, rdat;
   logic [31:0] m [5];
   logic [8:0] at [5] = '{9'h0bc, 9'h0f4, 9'h0b0, 9'h0d8, 9'h0f8};
   int bad_count = 0, compares = 0, ev_exp = 0, ev_seen = 0;
   always #2.5 clk = ~clk;
   // Pulse counted at the falling edge, where the registered output has settled
   always @(negedge clk) ev_seen += (ev === 1'b1);
   bcs_stat_bank dut (.CLK_SYS(clk), .RESET(rst), .GLOBAL_COUNT_ENABLE(ge),
      .PER_COUNTER_MASK(msk), .RX_FRAME_DONE(rxd), .RX_BROADCAST(rxb), .RX_TOO_LONG(rxe[0]),
      .RX_FCS_ERR(rxe[1]), .RX_LEN_ERR(rxe[2]), .RX_ALIGN_ERR(rxe[3]), .RX_OVERRUN(rxe[4]),
      .RX_OCTETS(rxo), .RX_VLAN_STRIPPED(rxv), .TX_FRAME_DONE(txd), .TX_OK(txok),
      .TX_BROADCAST(txb), .TX_OCTETS(txo), .TX_VLAN_INSERTED(txv), .TX_ACTIVE(txa),
      .TX_SFD_SENT(sfd), .TX_COLLISION(col), .CRS(crs), .HOST_ADDR(addr), .HOST_WR(wr),
      .HOST_WDATA(wd), .HOST_RD(rd), .HOST_RDATA(rdat), .HOST_RVALID(rv),
      .COUNTER_THRESHOLD_EVENT(ev));
   function automatic logic [31:0] lim(int i);
      return (i == 2 || i == 3) ? 32'hffffffff : 32'h0000ffff;
   endfunction
   task automatic stop_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   // Threshold is three quarters of full scale; wrap by masking; returns a crossing
   function automatic bit bump(int i, logic [31:0] amt);
      logic [31:0] n;
      logic [31:0] th;
      n = (m[i] + amt) & lim(i);
      th = lim(i) ^ (lim(i) >> 2);
      bump = 1'b0;
      if (ge && !msk[i])
      begin
         bump = (m[i] < th) && (n >= th);
         m[i] = n;
      end
   endfunction
   // Idle cycle after each read so the strobe never re-rises in one step
   task automatic rdc(logic [8:0] a, logic [31:0] e);
      addr = a;
      rd = 1;
      @(negedge clk);
      rd = 0;
      chk("valid", {31'h0, rv}, 1);
      chk("data", rdat, e);
      @(negedge clk);
   endtask
   task automatic wra(logic [8:0] a, logic [31:0] v);
      addr = a;
      wd = v;
      wr = 1;
      @(negedge clk);
      wr = 0;
   endtask
   task automatic wrr(int i, logic [31:0] v);
      m[i] = v & lim(i);
      wra(at[i], v & lim(i));
   endtask
   task automatic rnd(bit f);
      ge = f | ($urandom % 4 != 0);
      msk = f ? 5'h00 : 5'($urandom % 4 == 0 ? $urandom : 0);
   endtask
   task automatic fin(int i, int j);
      rdc(at[i], m[i]);
      rdc(at[j], m[j]);
      @(negedge clk);
      chk("events", ev_seen, ev_exp);
   endtask
   task automatic rxf(bit f);
      rnd(f);
      rxb = f | ($urandom % 4 != 0);
      rxe = f ? 5'h00 : 5'($urandom % 3 == 0 ? 1 << ($urandom % 5) : 0);
      rxo = 16'($urandom % 1600);
      rxv = 1'($urandom);
      rxd = 1;
      // Two counters crossing in one cycle still give a single pulse
      if (rxb && rxe == 0)
         ev_exp += (bump(0, 1) | bump(2, rxo + (rxv ? 4 : 0)));
      @(negedge clk);
      rxd = 0;
      fin(0, 2);
   endtask
   task automatic txf(bit f);
      rnd(f);
      txok = f | ($urandom % 4 != 0);
      txb = f | 1'($urandom);
      txo = 16'($urandom % 1600);
      txv = 1'($urandom);
      txd = 1;
      if (txok && txb)
         ev_exp += (bump(1, 1) | bump(3, txo + (txv ? 4 : 0)));
      @(negedge clk);
      txd = 0;
      fin(1, 3);
   endtask
   // Carrier drops before the delimiter, after a collision, and after the delimiter
   task automatic car(bit f, bit pre, bit c);
      rnd(f);
      txa = 1;
      crs = 1;
      @(negedge clk);
      crs = !pre;
      @(negedge clk);
      crs = 1;
      sfd = 1;
      col = c;
      @(negedge clk);
      col = 0;
      @(negedge clk);
      crs = 0;
      if (!c) ev_exp += bump(4, 1);
      @(negedge clk);
      txa = 0;
      sfd = 0;
      fin(4, 4);
   endtask
   initial
   begin
      void'($urandom(63904));
      repeat (4) @(negedge clk);
      rst = 0;
      foreach (at[i]) rdc(at[i], 0);
      wra(9'h0c0, $urandom);
      rdc(9'h0c0, 0);
      foreach (at[i])
      begin
         wrr(i, $urandom);
         rdc(at[i], m[i]);
      end
      // Load just under threshold, then all ones, then count once
      for (int k = 0; k < 10; k++)
      begin
         wrr(k % 5, k < 5 ? (lim(k % 5) ^ (lim(k % 5) >> 2)) - 1 : lim(k % 5));
         if (k % 5 == 4) car(1, 0, 0);
         else if (k % 2 == 0) rxf(1);
         else txf(1);
      end
      repeat (30)
      begin
         rxf(0);
         txf(0);
         car(0, 1'($urandom), 1'($urandom % 4 == 0));
      end
      stop_test();
   end
   initial
   begin
      #100000;
      bad_count++;
      stop_test();
   end
endmodule
`default_nettype wire
